/* File: shbpwm_top.sv */
// Purpose: Half-bridge PWM controller with switch setup, buttons, indicators
// Assumes: 200 MHz aclk, buttons and switch are asynchronous pins
// Notes: Duty value is an ADC word on the aclk domain
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module shbpwm_top #(
  parameter int MS_CYC = shbpwm_pkg::MS_CYC_DEFAULT,
  parameter int STEP_MS = shbpwm_pkg::LED_STEP_MS,
  parameter int BLINK_MS = shbpwm_pkg::BLINK_HALF_MS,
  parameter int DEB_MS = shbpwm_pkg::DEBOUNCE_MS,
  parameter int DUTY_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] dip_switch,
  input wire logic start_stop_button_n,
  input wire logic sleep_button_n,
  input wire logic [DUTY_W-1:0] duty_potentiometer,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic high_side_drive,
  output logic low_side_drive,
  output logic logic_ldo_enable,
  output logic gate_ldo_enable,
  output logic drive_buffer_enable_n,
  output logic rail_enable_buffer_enable_n,
  output shbpwm_pkg::shbpwm_leds_s indicators
);
  localparam int PW = shbpwm_pkg::PERIOD_W;
  localparam int DW = shbpwm_pkg::DEAD_W;

  shbpwm_pkg::shbpwm_state_e state_reg, state_next;
  shbpwm_pkg::shbpwm_cfg_s cfg_reg;
  shbpwm_pkg::shbpwm_leds_s leds_reg;
  logic [5:0] dip_meta_reg, dip_sync_reg;
  logic [17:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [1:0] seq_step_reg;
  logic [9:0] seq_ms_reg, blink_ms_reg;
  logic blink_reg;
  logic [PW-1:0] pwm_cnt_reg;
  logic [DW-1:0] dead_cnt_reg;
  logic target_reg, hs_reg, ls_reg, drv_rel_reg, rail_rel_reg;
  logic [1:0] ldo_reg;
  logic sw_ss_reg, sw_sl_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [31:0] awaddr_reg, wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [DW:0] low_gap_reg;
  localparam int BUTTONS_W = shbpwm_pkg::BUTTONS;
  logic capture;
  logic [BUTTONS_W-1:0] press;
  logic [PW-1:0] period_tab [shbpwm_pkg::CODES];

  // Buttons, sampled every clock and debounced on ms ticks
  wire [BUTTONS_W-1:0] button_n = {sleep_button_n, start_stop_button_n};
  genvar gi;
  generate
    for (gi = 0; gi < BUTTONS_W; gi++) begin : g_btn
      shbpwm_debounce #(.DEB_MS(DEB_MS)) u_deb (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_ms(ms_tick_reg),
        .button_n(button_n[gi]),
        .press(press[gi])
      );
    end
    for (gi = 0; gi < shbpwm_pkg::CODES; gi++) begin : g_period
      assign period_tab[gi] = PW'(shbpwm_pkg::CLK_HZ / (shbpwm_pkg::FREQ_STEP_HZ * (gi + 1)));
    end
  endgenerate

  wire ss_ev = press[shbpwm_pkg::BTN_START_STOP] | sw_ss_reg;
  wire sl_ev = press[shbpwm_pkg::BTN_SLEEP] | sw_sl_reg;
  wire all_on = dip_sync_reg == shbpwm_pkg::EXT_CODE;
  wire running = state_reg == shbpwm_pkg::ST_RUNNING;
  wire in_seq = state_reg == shbpwm_pkg::ST_POWER_SEQ;
  wire in_ext = state_reg == shbpwm_pkg::ST_EXTERNAL;
  wire in_sleep = state_reg == shbpwm_pkg::ST_SLEEP;
  wire ms_wrap = ms_cnt_reg == 18'(MS_CYC - 1);
  wire step_end = ms_tick_reg && (seq_ms_reg == 10'(STEP_MS - 1));
  wire seq_done = step_end && (seq_step_reg == shbpwm_pkg::LAST_SEQ_STEP);
  wire blink_end = ms_tick_reg && (blink_ms_reg == 10'(BLINK_MS - 1));
  wire start_cmd = ss_ev && !all_on;

  // Fixed periods; a running frame never sees the switch change
  wire [PW-1:0] period_cyc = period_tab[cfg_reg.freq_code];
  wire [DW-1:0] dead_cyc = DW'(cfg_reg.dead_code * shbpwm_pkg::DEAD_STEP_CYC);
  wire [PW+DUTY_W-1:0] on_prod = period_cyc * duty_potentiometer;
  wire [PW-1:0] on_cyc = on_prod[PW+DUTY_W-1 -: PW];
  wire raw_high = running && (pwm_cnt_reg < on_cyc);
  wire pwm_wrap = pwm_cnt_reg == (period_cyc - 16'h0001);

  always_comb begin
    state_next = state_reg;
    capture = 1'b0;
    case (state_reg)
      shbpwm_pkg::ST_POWER_SEQ: begin
        if (seq_done) begin
          state_next = shbpwm_pkg::ST_STOPPED;
        end
      end
      shbpwm_pkg::ST_STOPPED: begin
        if (ss_ev) begin
          capture = 1'b1;
          state_next = all_on ? shbpwm_pkg::ST_EXTERNAL : shbpwm_pkg::ST_RUNNING;
        end else if (sl_ev) begin
          state_next = shbpwm_pkg::ST_SLEEP;
        end
      end
      shbpwm_pkg::ST_RUNNING: begin
        // Sleep wins when both buttons land together: safer to stop
        if (sl_ev) begin
          state_next = shbpwm_pkg::ST_SLEEP;
        end else if (ss_ev) begin
          state_next = shbpwm_pkg::ST_STOPPED;
        end
      end
      shbpwm_pkg::ST_SLEEP: begin
        if (ss_ev) begin
          capture = 1'b1;
          state_next = all_on ? shbpwm_pkg::ST_EXTERNAL : shbpwm_pkg::ST_RUNNING;
        end else if (sl_ev) begin
          state_next = shbpwm_pkg::ST_STOPPED;
        end
      end
      shbpwm_pkg::ST_EXTERNAL: begin
        // Start/stop ignored so the indicator stays lit while configured
        if (!all_on) begin
          state_next = shbpwm_pkg::ST_STOPPED;
        end
      end
      default: state_next = shbpwm_pkg::ST_POWER_SEQ;
    endcase
  end

  // Control, timing and switch sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= shbpwm_pkg::ST_POWER_SEQ;
      dip_meta_reg <= 6'h00;
      dip_sync_reg <= 6'h00;
      cfg_reg <= '0;
      ms_cnt_reg <= 18'h00000;
      ms_tick_reg <= 1'b0;
      seq_step_reg <= 2'h0;
      seq_ms_reg <= 10'h000;
      blink_ms_reg <= 10'h000;
      blink_reg <= 1'b0;
    end else begin
      dip_meta_reg <= dip_switch;
      dip_sync_reg <= dip_meta_reg;
      state_reg <= state_next;
      if (capture) begin
        cfg_reg <= dip_sync_reg;
      end
      ms_cnt_reg <= ms_wrap ? 18'h00000 : ms_cnt_reg + 18'h00001;
      ms_tick_reg <= ms_wrap;
      if (step_end) begin
        seq_ms_reg <= 10'h000;
        seq_step_reg <= seq_step_reg + 2'h1;
      end else if (ms_tick_reg && in_seq) begin
        seq_ms_reg <= seq_ms_reg + 10'h001;
      end
      if (state_next != shbpwm_pkg::ST_RUNNING || capture) begin
        blink_ms_reg <= 10'h000;
        blink_reg <= 1'b1;
      end else if (blink_end) begin
        blink_ms_reg <= 10'h000;
        blink_reg <= !blink_reg;
      end else if (ms_tick_reg) begin
        blink_ms_reg <= blink_ms_reg + 10'h001;
      end
    end
  end

  // Gate drive with dead-time; any edge of the raw PWM forces both low first
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      pwm_cnt_reg <= '0;
      dead_cnt_reg <= '0;
      target_reg <= 1'b0;
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_wrap ? '0 : pwm_cnt_reg + 16'h0001;
      if (raw_high != target_reg) begin
        target_reg <= raw_high;
        hs_reg <= 1'b0;
        ls_reg <= 1'b0;
        dead_cnt_reg <= dead_cyc;
      end else if (dead_cnt_reg != '0) begin
        dead_cnt_reg <= dead_cnt_reg - 10'h001;
      end else begin
        hs_reg <= target_reg;
        ls_reg <= !target_reg;
      end
    end
  end

  // Indicators and output release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      leds_reg <= '0;
      drv_rel_reg <= 1'b1;
      rail_rel_reg <= 1'b1;
    end else begin
      leds_reg.run_indicator <= (in_seq && seq_step_reg == 2'h0) || (running && blink_reg);
      leds_reg.sleep_indicator <= (in_seq && seq_step_reg == 2'h1) || in_sleep;
      leds_reg.spare_indicator <= in_seq && seq_step_reg == 2'h2;
      leds_reg.external_mode_indicator <= (in_seq && seq_step_reg == 2'h3) || in_ext;
      drv_rel_reg <= all_on || in_ext;
      rail_rel_reg <= all_on || in_ext;
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  wire aw_take = awvalid && awready_reg;
  wire w_take = wvalid && wready_reg;
  wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_ctrl = do_write && (awaddr_reg == shbpwm_pkg::CTRL_OFS);
  wire wr_hit = wr_ctrl || (awaddr_reg == shbpwm_pkg::STATUS_OFS);
  wire ar_take = arvalid && arready_reg;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[shbpwm_pkg::ST_RUN_BIT] = running;
    status_word[shbpwm_pkg::ST_SLEEP_BIT] = in_sleep;
    status_word[shbpwm_pkg::ST_EXT_BIT] = in_ext;
    status_word[shbpwm_pkg::ST_SEQ_BIT] = in_seq;
    status_word[shbpwm_pkg::ST_FREQ_LSB +: 3] = cfg_reg.freq_code;
    status_word[shbpwm_pkg::ST_DEAD_LSB +: 3] = cfg_reg.dead_code;
    status_word[shbpwm_pkg::ST_DIP_LSB +: 6] = dip_sync_reg;
    status_word[shbpwm_pkg::ST_DUTY_LSB +: 8] = 8'(duty_potentiometer);
  end
  wire rd_ctrl = araddr == shbpwm_pkg::CTRL_OFS;
  wire rd_stat = araddr == shbpwm_pkg::STATUS_OFS;
  wire [31:0] rd_word = rd_ctrl ? {30'h0, ldo_reg} : (rd_stat ? status_word : 32'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= shbpwm_pkg::RESP_OKAY;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= shbpwm_pkg::RESP_OKAY;
      ldo_reg <= shbpwm_pkg::CTRL_LDO_RESET;
      sw_ss_reg <= 1'b0;
      sw_sl_reg <= 1'b0;
    end else begin
      sw_ss_reg <= 1'b0;
      sw_sl_reg <= 1'b0;
      if (aw_take) begin
        awaddr_reg <= awaddr;
        awready_reg <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? shbpwm_pkg::RESP_OKAY : shbpwm_pkg::RESP_SLVERR;
      end
      if (wr_ctrl && wstrb_reg[0]) begin
        ldo_reg <= {wdata_reg[shbpwm_pkg::CTRL_GATE_LDO_BIT],
                    wdata_reg[shbpwm_pkg::CTRL_LOGIC_LDO_BIT]};
        sw_ss_reg <= wdata_reg[shbpwm_pkg::CTRL_START_STOP_BIT];
        sw_sl_reg <= wdata_reg[shbpwm_pkg::CTRL_SLEEP_BIT];
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= (rd_ctrl || rd_stat) ? shbpwm_pkg::RESP_OKAY : shbpwm_pkg::RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign high_side_drive = hs_reg;
  assign low_side_drive = ls_reg;
  assign logic_ldo_enable = ldo_reg[0];
  assign gate_ldo_enable = ldo_reg[1];
  assign drive_buffer_enable_n = drv_rel_reg;
  assign rail_enable_buffer_enable_n = rail_rel_reg;
  assign indicators = leds_reg;

  // Checking helper: consecutive cycles with both drives low
  always_ff @(posedge aclk) begin
    if (!aresetn || hs_reg || ls_reg) begin
      low_gap_reg <= '0;
    end else if (low_gap_reg != '1) begin
      low_gap_reg <= low_gap_reg + 11'h001;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  never_both_high_a: assert property (!(hs_reg && ls_reg))
    else $error("both drives high");
  dead_gap_a: assert property (($rose(hs_reg) || $rose(ls_reg)) |-> $past(low_gap_reg) >= dead_cyc)
    else $error("dead-time too short");
  release_a: assert property ((all_on || in_ext) |=> drive_buffer_enable_n && rail_enable_buffer_enable_n)
    else $error("outputs not released");
  ext_led_a: assert property (in_ext |=> indicators.external_mode_indicator)
    else $error("external indicator dark");
  cfg_hold_a: assert property (running && $past(running) |-> $stable(cfg_reg))
    else $error("config changed while running");
  idle_low_a: assert property (!running |=> !hs_reg && !ls_reg)
    else $error("drive while not running");
  start_run_a: assert property (state_reg == shbpwm_pkg::ST_STOPPED && start_cmd |=> running ##1 indicators.run_indicator)
    else $error("start did not run");
  run_stop_a: assert property (running && ss_ev && !sl_ev |=> state_reg == shbpwm_pkg::ST_STOPPED ##1 !indicators.run_indicator)
    else $error("stop did not stop");
  sleep_enter_a: assert property (running && sl_ev |=> in_sleep ##1 indicators.sleep_indicator && !hs_reg)
    else $error("sleep did not stop pwm");
  sleep_wake_a: assert property (in_sleep && start_cmd |=> running ##1 !indicators.sleep_indicator)
    else $error("wake failed");
  sleep_toggle_a: assert property (in_sleep && sl_ev && !ss_ev |=> state_reg == shbpwm_pkg::ST_STOPPED)
    else $error("sleep did not toggle off");
  zero_duty_a: assert property (running && duty_potentiometer == '0 |=> !hs_reg)
    else $error("pulse at zero duty");
endmodule
`default_nettype wire

/* File: shbpwm_pkg.sv */
// Purpose: Shared constants and types for the switch-configured half-bridge PWM block
// Assumes: 200 MHz system clock
// Notes: Register map is two words on AXI4-Lite
`default_nettype none
package shbpwm_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FREQ_STEP_HZ = 5_000;
  localparam int DEAD_STEP_NS = 400;
  localparam int DEAD_STEP_CYC = DEAD_STEP_NS / CLK_PERIOD_NS;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC_DEFAULT = MS_NS / CLK_PERIOD_NS;
  localparam int LED_STEP_MS = 250;
  localparam int BLINK_HALF_MS = 250;
  localparam int DEBOUNCE_MS = 10;
  localparam int PERIOD_W = 16;
  localparam int DEAD_W = 10;
  localparam int CODE_W = 3;
  localparam int CODES = 8;
  localparam int BUTTONS = 2;
  localparam int BTN_START_STOP = 0;
  localparam int BTN_SLEEP = 1;
  localparam logic [5:0] EXT_CODE = 6'h3f;
  localparam logic [1:0] LAST_SEQ_STEP = 2'h3;
  // Register map
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam int CTRL_LOGIC_LDO_BIT = 0;
  localparam int CTRL_GATE_LDO_BIT = 1;
  localparam int CTRL_START_STOP_BIT = 2;
  localparam int CTRL_SLEEP_BIT = 3;
  localparam logic [1:0] CTRL_LDO_RESET = 2'h3;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_EXT_BIT = 2;
  localparam int ST_SEQ_BIT = 3;
  localparam int ST_FREQ_LSB = 4;
  localparam int ST_DEAD_LSB = 8;
  localparam int ST_DIP_LSB = 16;
  localparam int ST_DUTY_LSB = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_POWER_SEQ = 3'h0,
    ST_STOPPED = 3'h1,
    ST_RUNNING = 3'h3,
    ST_SLEEP = 3'h2,
    ST_EXTERNAL = 3'h6
  } shbpwm_state_e;

  typedef struct packed {
    logic [CODE_W-1:0] dead_code;
    logic [CODE_W-1:0] freq_code;
  } shbpwm_cfg_s;

  typedef struct packed {
    logic external_mode_indicator;
    logic spare_indicator;
    logic sleep_indicator;
    logic run_indicator;
  } shbpwm_leds_s;
endpackage
`default_nettype wire

/* File: shbpwm_debounce.sv */
// Purpose: Button synchroniser and debouncer, one pulse per press
// Assumes: Active-low button, ms tick enable from the top
// Notes: Level must be stable for DEB_MS ticks before it is accepted
`timescale 1ns/100ps
`default_nettype none
module shbpwm_debounce #(
  parameter int DEB_MS = shbpwm_pkg::DEBOUNCE_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_ms,
  input wire logic button_n,
  output logic press
);
  logic meta_reg, sync_reg, stable_reg, press_reg;
  logic [7:0] cnt_reg;
  wire differs = sync_reg != stable_reg;
  wire settled = tick_ms && (cnt_reg == 8'(DEB_MS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      stable_reg <= 1'b1;
      cnt_reg <= 8'h00;
      press_reg <= 1'b0;
    end else begin
      meta_reg <= button_n;
      sync_reg <= meta_reg;
      press_reg <= 1'b0;
      if (!differs) begin
        cnt_reg <= 8'h00;
      end else if (settled) begin
        stable_reg <= sync_reg;
        press_reg <= !sync_reg;
        cnt_reg <= 8'h00;
      end else if (tick_ms) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  assign press = press_reg;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  single_pulse_a: assert property (press |=> !press) else $error("press lasted two cycles");
  press_edge_a: assert property (press |-> !stable_reg && $past(stable_reg))
    else $error("press without a new accepted low level");
endmodule
`default_nettype wire

/* File: shbpwm_gate_model.sv */
// Purpose: Gate driver side of the drive and rail pins, behind the release buffer
// Assumes: Buffer enables active low; the off-board source is always present
// Notes: Latches any cycle in which both drive pins are high
`timescale 1ns/100ps
`default_nettype none
module shbpwm_gate_model (
  input wire logic aclk,
  input wire logic hs_in,
  input wire logic ls_in,
  input wire logic [1:0] ldo_in,
  input wire logic drv_rel_n,
  input wire logic rail_rel_n,
  input wire logic [3:0] ext_in,
  output logic hs_pin,
  output logic ls_pin,
  output logic [1:0] ldo_pin,
  output var logic overlap_seen
);
  // A released buffer hands the pins to the off-board source
  assign hs_pin = drv_rel_n ? ext_in[3] : hs_in;
  assign ls_pin = drv_rel_n ? ext_in[2] : ls_in;
  assign ldo_pin = rail_rel_n ? ext_in[1:0] : ldo_in;
  initial overlap_seen = 1'b0;
  // Shoot-through would short the bridge, so it is kept
  always @(posedge aclk) begin
    if (hs_pin === 1'b1 && ls_pin === 1'b1) begin
      overlap_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for the half-bridge PWM controller
// Assumes: Shortened ms tick (20 cycles), 3 ms steps, 2 ms debounce
// Notes: Periods are counted on falling clock edges
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk, aresetn, start_stop_button_n, sleep_button_n, overlap_seen;
  logic [5:0] dip_switch;
  logic [7:0] duty_potentiometer;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb, ext_in;
  logic [1:0] bresp, rresp, ldo_pin, r;
  logic high_side_drive, low_side_drive, logic_ldo_enable, gate_ldo_enable, hs_pin, ls_pin;
  logic drive_buffer_enable_n, rail_enable_buffer_enable_n;
  shbpwm_pkg::shbpwm_leds_s indicators;
  int errors = 0;
  int checks_done = 0;
  int n, a, b;
  logic [5:0] dip_row [8] = '{6'h08, 6'h11, 6'h1a, 6'h23, 6'h2c, 6'h35, 6'h3e, 6'h07};
  logic [31:0] exp_row [8] = '{32'h101, 32'h211, 32'h321, 32'h431, 32'h541, 32'h651,
    32'h761, 32'h071};

  shbpwm_top #(.MS_CYC(20), .STEP_MS(3), .BLINK_MS(3), .DEB_MS(2), .DUTY_W(8)) i_shbpwm_top (
    .aclk(aclk), .aresetn(aresetn), .dip_switch(dip_switch),
    .start_stop_button_n(start_stop_button_n), .sleep_button_n(sleep_button_n),
    .duty_potentiometer(duty_potentiometer), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .logic_ldo_enable(logic_ldo_enable), .gate_ldo_enable(gate_ldo_enable),
    .drive_buffer_enable_n(drive_buffer_enable_n),
    .rail_enable_buffer_enable_n(rail_enable_buffer_enable_n), .indicators(indicators));

  shbpwm_gate_model i_shbpwm_gate_model (.aclk(aclk), .hs_in(high_side_drive),
    .ls_in(low_side_drive), .ldo_in({logic_ldo_enable, gate_ldo_enable}),
    .drv_rel_n(drive_buffer_enable_n), .rail_rel_n(rail_enable_buffer_enable_n),
    .ext_in(ext_in), .hs_pin(hs_pin), .ls_pin(ls_pin), .ldo_pin(ldo_pin),
    .overlap_seen(overlap_seen));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("Counts: checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Held well past the debounce span on both press and release
  task automatic press(input bit slp);
    @(posedge aclk);
    if (slp) begin
      sleep_button_n <= 1'b0;
    end else begin
      start_stop_button_n <= 1'b0;
    end
    cyc(100);
    sleep_button_n <= 1'b1;
    start_stop_button_n <= 1'b1;
    cyc(100);
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Falling edges until the chosen drive shows the level
  task automatic cnt(input bit ls, input logic lvl, output int k);
    k = 0;
    while ((ls ? low_side_drive : high_side_drive) !== lvl && k < 20000) begin
      @(negedge aclk);
      k++;
    end
  endtask

  task automatic blink(output int k);
    logic p;
    k = 0;
    p = indicators.run_indicator;
    repeat (400) begin
      @(negedge aclk);
      if (indicators.run_indicator !== p) k++;
      p = indicators.run_indicator;
    end
  endtask

  task automatic pwr_seq;
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cyc(i == 0 ? 30 : 60);
      chk(32'(indicators), 32'h1 << i);
    end
    cyc(100);
    chk({30'h0, high_side_drive, low_side_drive}, 32'h0);
    chk(32'(indicators), 32'h0);
  endtask

  initial begin
    #300000;
    errors++;
    $display("Watchdog expired");
    summarize();
  end

  initial begin
    aresetn = 1'b0;
    dip_switch = 6'h0f;
    start_stop_button_n = 1'b1;
    sleep_button_n = 1'b1;
    duty_potentiometer = 8'h80;
    awaddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 32'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    ext_in = 4'h9;
    pwr_seq();
    $display("Test power-up done");
    for (int i = 0; i < 8; i++) begin
      dip_switch <= dip_row[i];
      cyc(5);
      press(0);
      rd(shbpwm_pkg::STATUS_OFS, d, r);
      chk(d & 32'h771, exp_row[i]);
      press(0);
      rd(shbpwm_pkg::STATUS_OFS, d, r);
      chk(d & 32'h1, 32'h0);
    end
    $display("Test switch table done");
    dip_switch <= 6'h0f;
    cyc(5);
    press(0);
    blink(n);
    chk(32'(n > 3), 32'h1);
    cnt(0, 0, n);
    cnt(0, 1, n);
    cnt(0, 0, a);
    cnt(0, 1, b);
    chk(32'(a + b), 32'h1388);
    cnt(1, 1, n);
    cnt(1, 0, n);
    cnt(0, 1, b);
    chk(32'(b), 32'h51);
    @(posedge aclk);
    dip_switch <= 6'h00;
    cyc(10);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h771, 32'h171);
    duty_potentiometer <= 8'h00;
    cyc(6000);
    n = 0;
    repeat (5000) begin
      @(negedge aclk);
      if (high_side_drive !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    @(posedge aclk);
    duty_potentiometer <= 8'h80;
    $display("Test timing done");
    press(1);
    chk(32'(indicators), 32'h2);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h3, 32'h2);
    press(1);
    chk(32'(indicators), 32'h0);
    press(1);
    press(0);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h3, 32'h1);
    blink(n);
    chk(32'(n > 3), 32'h1);
    press(0);
    $display("Test sleep done");
    wr(shbpwm_pkg::CTRL_OFS, 32'h0, r);
    chk(32'(r), 32'(shbpwm_pkg::RESP_OKAY));
    chk({30'h0, logic_ldo_enable, gate_ldo_enable}, 32'h0);
    rd(shbpwm_pkg::CTRL_OFS, d, r);
    chk(d & 32'h3, 32'h0);
    wr(shbpwm_pkg::CTRL_OFS, 32'h3, r);
    chk({30'h0, logic_ldo_enable, gate_ldo_enable}, 32'h3);
    wr(shbpwm_pkg::CTRL_OFS, 32'h7, r);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h3, 32'h1);
    wr(shbpwm_pkg::CTRL_OFS, 32'hb, r);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h3, 32'h2);
    wr(shbpwm_pkg::CTRL_OFS, 32'hb, r);
    rd(shbpwm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h3, 32'h0);
    rd(32'h10, d, r);
    chk(32'(r), 32'(shbpwm_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    wr(shbpwm_pkg::STATUS_OFS, 32'hffff_ffff, r);
    chk(32'(r), 32'(shbpwm_pkg::RESP_OKAY));
    $display("Test register bus done");
    dip_switch <= 6'h3f;
    cyc(10);
    chk({30'h0, drive_buffer_enable_n, rail_enable_buffer_enable_n}, 32'h3);
    chk({28'h0, hs_pin, ls_pin, ldo_pin}, 32'(ext_in));
    press(0);
    chk(32'(indicators), 32'h8);
    dip_switch <= 6'h0f;
    cyc(10);
    chk({31'h0, drive_buffer_enable_n}, 32'h0);
    $display("Test external done");
    press(0);
    cyc(200);
    pwr_seq();
    chk({31'h0, overlap_seen}, 32'h0);
    $display("Test reset done");
    summarize();
  end
endmodule
`default_nettype wire
